// File: rtl/acl_pkg.sv
// package: register map, field positions and reset values of the bank
package acl_pkg;

	// ------------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------------
	localparam logic [7:0] ADDR_ANALOG_CONFIG   = 8'h02;
	localparam logic [7:0] ADDR_LEAD_OFF_CONTROL = 8'h03;

	// ------------------------------------------------------------------
	// reset values (fixed bits included)
	// ------------------------------------------------------------------
	localparam logic [7:0] RST_ANALOG_CONFIG    = 8'h80;
	localparam logic [7:0] RST_LEAD_OFF_CONTROL = 8'h10;

	// ------------------------------------------------------------------
	// analog_config fields
	// ------------------------------------------------------------------
	localparam int AC_FIXED_ONE_BIT    = 7;
	localparam int AC_COMP_EN_BIT      = 6;
	localparam int AC_REFBUF_EN_BIT    = 5;
	localparam int AC_HIGH_REF_BIT     = 4;
	localparam int AC_CLK_OUT_BIT      = 3;
	localparam int AC_FIXED_ZERO_BIT   = 2;
	localparam int AC_TEST_ON_BIT      = 1;
	localparam int AC_TEST_RATE_BIT    = 0;

	// ------------------------------------------------------------------
	// lead_off_control fields
	// ------------------------------------------------------------------
	localparam int LC_THRESH_MSB       = 7;
	localparam int LC_THRESH_LSB       = 5;
	localparam int LC_FIXED_ONE_BIT    = 4;
	localparam int LC_CURRENT_MSB      = 3;
	localparam int LC_CURRENT_LSB      = 2;
	localparam int LC_FIXED_ZERO_BIT   = 1;
	localparam int LC_AC_SELECT_BIT    = 0;

	// unmapped reads return this value
	localparam logic [7:0] RD_UNMAPPED = 8'h00;

endpackage : acl_pkg

// File: rtl/acl_reg8.sv
// file: one 8-bit control register with reset value and write enable
`timescale 1ns/1ps

module acl_reg8 #(
	parameter logic [7:0] RST_VAL = 8'h00
) (
	input  wire logic       i_mclk,
	input  wire logic       i_rst,
	input  wire logic       i_we,
	input  wire logic [7:0] i_wdata,
	output logic      [7:0] o_q
);

	// plain storage; fixed bits are whatever the host writes
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			o_q <= RST_VAL;
		end else if (i_we) begin
			o_q <= i_wdata;
		end
	end

endmodule : acl_reg8

// File: rtl/acl_config_leadoff_regs.sv
// file: analog configuration and lead-off control register bank
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
// What this block does
// R1: bit 6 enables lead-off comparators, default off
// R2: bit 5 enables reference buffer, default off
// R3: bit 4 selects 4.033 V reference, else 2.42 V
// R4: bit 3 drives oscillator out on clock pin
// R5: bit 1 turns internal test signal on
// R6: bit 0 selects 1 Hz square, else dc
// R7: lead-off bits 7:5 set comparator threshold
// R8: lead-off bits 3:2 set excitation current
// R9: lead-off bit 0 selects ac detection
// R10: host writes fixed bits at required values

module acl_config_leadoff_regs (
	input  wire logic       i_mclk,
	input  wire logic       i_rst,
	input  wire logic [7:0] i_addr,
	input  wire logic [7:0] i_wdata,
	input  wire logic       i_wr,
	input  wire logic       i_rd,
	input  wire logic       i_int_osc_used,
	output logic      [7:0] o_rdata,
	output logic            o_detect_comparator_enable,
	output logic            o_reference_buffer_enable,
	output logic            o_high_reference_select,
	output logic            o_clock_out_enable,
	output logic            o_test_signal_enable,
	output logic            o_test_signal_rate,
	output logic      [2:0] o_comparator_threshold,
	output logic      [1:0] o_excitation_current_level,
	output logic            o_detect_ac_select
);

	// ------------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------------
	logic [7:0] analog_config_r;
	logic [7:0] lead_off_control_r;
	logic [7:0] rdata_nxt;
	logic       we_ac;
	logic       we_lc;

	// decode shared by the write path and the read path
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction : hit

	assign we_ac = i_wr & hit(i_addr, acl_pkg::ADDR_ANALOG_CONFIG);
	assign we_lc = i_wr & hit(i_addr, acl_pkg::ADDR_LEAD_OFF_CONTROL);

	// ------------------------------------------------------------------
	// storage
	// ------------------------------------------------------------------
	// fixed bits are stored as written; the host keeps them right  R10
	acl_reg8 #(
		.RST_VAL (acl_pkg::RST_ANALOG_CONFIG)
	) u_analog_config (
		.i_mclk  (i_mclk),
		.i_rst   (i_rst),
		.i_we    (we_ac),
		.i_wdata (i_wdata),
		.o_q     (analog_config_r)
	);

	acl_reg8 #(
		.RST_VAL (acl_pkg::RST_LEAD_OFF_CONTROL)
	) u_lead_off_control (
		.i_mclk  (i_mclk),
		.i_rst   (i_rst),
		.i_we    (we_lc),
		.i_wdata (i_wdata),
		.o_q     (lead_off_control_r)
	);

	// ------------------------------------------------------------------
	// read port: data valid the cycle after the strobe
	// ------------------------------------------------------------------
	always_comb begin
		if (hit(i_addr, acl_pkg::ADDR_ANALOG_CONFIG)) begin
			rdata_nxt = analog_config_r;
		end else if (hit(i_addr, acl_pkg::ADDR_LEAD_OFF_CONTROL)) begin
			rdata_nxt = lead_off_control_r;
		end else begin
			rdata_nxt = acl_pkg::RD_UNMAPPED;
		end
	end

	// holds last read value; only meaningful the cycle after i_rd
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			o_rdata <= 8'h00;
		end else if (i_rd) begin
			o_rdata <= rdata_nxt;
		end
	end

	// ------------------------------------------------------------------
	// control outputs to the analog circuits
	// ------------------------------------------------------------------
	// straight from the register flops, except clock out, which is ANDed with i_int_osc_used
	assign o_detect_comparator_enable =
		analog_config_r[acl_pkg::AC_COMP_EN_BIT];        // R1
	assign o_reference_buffer_enable =
		analog_config_r[acl_pkg::AC_REFBUF_EN_BIT];      // R2
	assign o_high_reference_select =
		analog_config_r[acl_pkg::AC_HIGH_REF_BIT];       // R3
	// clock out only matters while the internal oscillator runs
	assign o_clock_out_enable = i_int_osc_used &
		analog_config_r[acl_pkg::AC_CLK_OUT_BIT];        // R4
	assign o_test_signal_enable =
		analog_config_r[acl_pkg::AC_TEST_ON_BIT];        // R5
	assign o_test_signal_rate =
		analog_config_r[acl_pkg::AC_TEST_RATE_BIT];      // R6
	assign o_comparator_threshold = lead_off_control_r[
		acl_pkg::LC_THRESH_MSB:acl_pkg::LC_THRESH_LSB];  // R7
	assign o_excitation_current_level = lead_off_control_r[
		acl_pkg::LC_CURRENT_MSB:acl_pkg::LC_CURRENT_LSB]; // R8
	assign o_detect_ac_select =
		lead_off_control_r[acl_pkg::LC_AC_SELECT_BIT];   // R9

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	// each analog_config write shows on its outputs one cycle later, clock out only while i_int_osc_used is high
	AST_COMP_EN: assert property (@(posedge i_mclk) disable iff (i_rst) // R1
		we_ac |=> o_detect_comparator_enable ==
			$past(i_wdata[acl_pkg::AC_COMP_EN_BIT]))
		else $error("comparator enable does not follow write");

	AST_REFBUF: assert property (@(posedge i_mclk) disable iff (i_rst) // R2
		we_ac |=> o_reference_buffer_enable ==
			$past(i_wdata[acl_pkg::AC_REFBUF_EN_BIT]))
		else $error("reference buffer enable does not follow write");

	AST_HIGH_REF: assert property (@(posedge i_mclk) disable iff (i_rst) // R3
		we_ac |=> o_high_reference_select ==
			$past(i_wdata[acl_pkg::AC_HIGH_REF_BIT]))
		else $error("reference select does not follow write");

	// clock out is never on without both the oscillator and the bit
	AST_CLK_OUT: assert property (@(posedge i_mclk) disable iff (i_rst) // R4
		o_clock_out_enable |->
			i_int_osc_used && analog_config_r[acl_pkg::AC_CLK_OUT_BIT])
		else $error("clock out enabled without oscillator and bit");

	AST_TEST_ON: assert property (@(posedge i_mclk) disable iff (i_rst) // R5
		(we_ac && !i_wdata[acl_pkg::AC_TEST_ON_BIT]) |=>
			!o_test_signal_enable)
		else $error("test signal not off after clear");

	AST_TEST_RATE: assert property (@(posedge i_mclk) disable iff (i_rst) // R6
		(!we_ac && $stable(analog_config_r)) |=> $stable(o_test_signal_rate))
		else $error("test rate changed without write");

	AST_THRESH: assert property (@(posedge i_mclk) disable iff (i_rst) // R7
		we_lc |=> o_comparator_threshold ==
			$past(i_wdata[acl_pkg::LC_THRESH_MSB:acl_pkg::LC_THRESH_LSB]))
		else $error("threshold does not follow write");

	AST_CURRENT: assert property (@(posedge i_mclk) disable iff (i_rst) // R8
		we_lc |=> o_excitation_current_level ==
			$past(i_wdata[acl_pkg::LC_CURRENT_MSB:acl_pkg::LC_CURRENT_LSB]))
		else $error("current level does not follow write");

	// the written value is the one sampled with the strobe, one cycle back
	AST_AC_SEL: assert property (@(posedge i_mclk) disable iff (i_rst) // R9
		(we_lc ##1 !we_lc) |->
			o_detect_ac_select == $past(i_wdata[acl_pkg::LC_AC_SELECT_BIT]))
		else $error("ac select not held after write");

	AST_READBACK: assert property (@(posedge i_mclk) disable iff (i_rst) // R7
		(i_rd && hit(i_addr, acl_pkg::ADDR_LEAD_OFF_CONTROL) && !i_wr)
		|=> o_rdata == lead_off_control_r)
		else $error("lead-off readback wrong");

	// ------------------------------------------------------------------
	// further checks: paths the write checks above leave open
	// ------------------------------------------------------------------
	// a write with bit 1 set must turn the test signal on as well
	AST_TEST_SET: assert property (@(posedge i_mclk) disable iff (i_rst) // R5
		we_ac |=> o_test_signal_enable ==
			$past(i_wdata[acl_pkg::AC_TEST_ON_BIT]))
		else $error("test signal does not follow write");

	// the rate check above covers holding only, this one covers writes
	AST_RATE_SET: assert property (@(posedge i_mclk) disable iff (i_rst) // R6
		we_ac |=> o_test_signal_rate ==
			$past(i_wdata[acl_pkg::AC_TEST_RATE_BIT]))
		else $error("test rate does not follow write");

	// with the oscillator running, clock out follows the written bit
	AST_CLK_SET: assert property (@(posedge i_mclk) disable iff (i_rst) // R4
		(we_ac ##1 i_int_osc_used) |->
			o_clock_out_enable == $past(i_wdata[acl_pkg::AC_CLK_OUT_BIT]))
		else $error("clock out does not follow write");

	// an external clock source must never see the pin driven
	AST_CLK_GATE: assert property (@(posedge i_mclk) disable iff (i_rst) // R4
		!i_int_osc_used |-> !o_clock_out_enable)
		else $error("clock out enabled without oscillator");

	// analog settings other than clock out move only on a write; a stray change upsets the
	// front end far more than a lost write would
	AST_AC_HOLD: assert property ( // R1 R2 R3 R5
		@(posedge i_mclk) disable iff (i_rst)
		!we_ac |=> $stable(o_detect_comparator_enable) &&
			$stable(o_reference_buffer_enable) &&
			$stable(o_high_reference_select) &&
			$stable(o_test_signal_enable))
		else $error("analog setting changed without write");

	AST_LC_HOLD: assert property ( // R7 R8 R9
		@(posedge i_mclk) disable iff (i_rst)
		!we_lc |=> $stable(o_comparator_threshold) &&
			$stable(o_excitation_current_level) &&
			$stable(o_detect_ac_select))
		else $error("lead-off setting changed without write");

	// config readback carries the value held when the strobe was taken
	AST_READ_AC: assert property (@(posedge i_mclk) disable iff (i_rst) // R1
		(i_rd && hit(i_addr, acl_pkg::ADDR_ANALOG_CONFIG) && !i_wr)
		|=> o_rdata == $past(analog_config_r))
		else $error("analog config readback wrong");

	// undecoded offsets read as a fixed pattern, never stale data
	AST_READ_NONE: assert property (@(posedge i_mclk) disable iff (i_rst)
		(i_rd && !hit(i_addr, acl_pkg::ADDR_ANALOG_CONFIG) &&
			!hit(i_addr, acl_pkg::ADDR_LEAD_OFF_CONTROL))
		|=> o_rdata == acl_pkg::RD_UNMAPPED)
		else $error("unmapped read not blank");

	// reset loads the default settings into both registers
	AST_RST_REGS: assert property (@(posedge i_mclk) i_rst |-> // R1 R7
		analog_config_r == acl_pkg::RST_ANALOG_CONFIG &&
		lead_off_control_r == acl_pkg::RST_LEAD_OFF_CONTROL &&
		o_rdata == 8'h00)
		else $error("register not at default during reset");

	// no analog control line may be active while reset is held
	AST_RST_OUTS: assert property (@(posedge i_mclk) i_rst |-> // R1 R4 R9
		!o_detect_comparator_enable && !o_reference_buffer_enable &&
		!o_high_reference_select && !o_clock_out_enable &&
		!o_test_signal_enable && !o_test_signal_rate &&
		o_comparator_threshold == 3'h0 &&
		o_excitation_current_level == 2'h0 && !o_detect_ac_select)
		else $error("control output active during reset");

endmodule : acl_config_leadoff_regs

// File: sim/acl_host.sv
// host model: drives the register port of the bank
`timescale 1ns/1ps
module acl_host (
	input  wire logic       i_mclk,
	input  wire logic [7:0] i_rdata,
	output logic      [7:0] o_addr,
	output logic      [7:0] o_wdata,
	output logic            o_wr,
	output logic            o_rd
);
	initial begin
		o_addr = 8'h00;
		o_wdata = 8'h00;
		o_wr = 1'b0;
		o_rd = 1'b0;
	end
	// fixed bits always carry the values the device needs
	function automatic logic [7:0] fix(input logic [7:0] a, d);
		if (a == acl_pkg::ADDR_ANALOG_CONFIG) return (d | 8'h80) & 8'hfb;
		if (a == acl_pkg::ADDR_LEAD_OFF_CONTROL) return (d | 8'h10) & 8'hfd;
		return d;
	endfunction : fix
	task automatic wr(input logic [7:0] a, d);
		@(posedge i_mclk);
		o_addr <= a;
		o_wdata <= fix(a, d);
		o_wr <= 1'b1;
		@(posedge i_mclk);
		o_wr <= 1'b0;
		o_wdata <= ~o_wdata; // stale data must not look valid
	endtask : wr
	// data stand from the cycle after the strobe until the next read
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge i_mclk);
		o_addr <= a;
		o_rd <= 1'b1;
		@(posedge i_mclk);
		o_rd <= 1'b0;
		@(negedge i_mclk);
		d = i_rdata;
	endtask : rd
endmodule : acl_host

// File: sim/tb_top.sv
// testbench: register bank reset, fields and unmapped access
`timescale 1ns/1ps
module tb_top;
	logic i_mclk, i_rst, i_osc, wr, rd;
	logic [7:0] addr, wd, rdat, r;
	logic [5:0] ao;
	logic [2:0] th;
	logic [1:0] cur;
	logic ac;
	int num_errors = 0;
	int cmp_count = 0;
	acl_host u_host (.i_mclk(i_mclk), .i_rdata(rdat), .o_addr(addr),
		.o_wdata(wd), .o_wr(wr), .o_rd(rd));
	acl_config_leadoff_regs dut (.i_mclk(i_mclk), .i_rst(i_rst),
		.i_addr(addr), .i_wdata(wd), .i_wr(wr), .i_rd(rd),
		.i_int_osc_used(i_osc), .o_rdata(rdat),
		.o_detect_comparator_enable(ao[5]),
		.o_reference_buffer_enable(ao[4]), .o_high_reference_select(ao[3]),
		.o_clock_out_enable(ao[2]), .o_test_signal_enable(ao[1]),
		.o_test_signal_rate(ao[0]), .o_comparator_threshold(th),
		.o_excitation_current_level(cur), .o_detect_ac_select(ac));
	// ------------------------------------------------------------------
	// checking and closing
	// ------------------------------------------------------------------
	task automatic chk(input logic [7:0] got, exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic test_done;
		$display("compares=%0d errors=%0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : test_done
	// ------------------------------------------------------------------
	// clock, reset and tests
	// ------------------------------------------------------------------
	initial begin
		i_mclk = 1'b0;
		forever #20 i_mclk = ~i_mclk;
	end
	// generous bound: the tests need well under a thousand cycles
	initial begin
		#200us;
		num_errors++;
		test_done;
	end
	initial begin
		i_rst = 1'b1;
		i_osc = 1'b1;
		repeat (2) @(posedge i_mclk);
		i_rst <= 1'b0;
		chk({2'b00, ao}, 8'h00);
		chk({th, cur, 2'b0, ac}, 8'h00);
		u_host.rd(8'h02, r);
		chk(r, 8'h80);
		u_host.rd(8'h03, r);
		chk(r, 8'h10);
		// one control bit at a time, fixed bits 7 and 2 skipped
		for (int i = 0; i < 7; i++) begin
			if (i == 2) continue;
			u_host.wr(8'h02, 8'h01 << i);
			@(negedge i_mclk); // new value shows after the write edge
			r = 8'h80 | (8'h01 << i);
			chk({2'b00, ao}, {2'b00, r[6:3], r[1:0]});
			u_host.rd(8'h02, r);
			chk(r, 8'h80 | (8'h01 << i));
		end
		// clock-out stays off unless the oscillator is in use
		u_host.wr(8'h02, 8'h08);
		i_osc <= 1'b0;
		@(negedge i_mclk);
		chk({7'h0, ao[2]}, 8'h00);
		@(posedge i_mclk);
		i_osc <= 1'b1;
		@(negedge i_mclk);
		chk({7'h0, ao[2]}, 8'h01);
		// every threshold and current code, ac toggled
		for (int i = 0; i < 32; i++) begin
			u_host.wr(8'h03, {i[2:0], 1'b0, i[4:3], 1'b0, i[0]});
			@(negedge i_mclk); // new value shows after the write edge
			chk({th, cur, 2'b0, ac}, {i[2:0], i[4:3], 2'b0, i[0]});
			u_host.rd(8'h03, r);
			chk(r, {i[2:0], 1'b1, i[4:3], 1'b0, i[0]});
		end
		// unmapped write leaves the bank alone and reads back zero
		u_host.wr(8'h05, 8'hff);
		u_host.rd(8'h05, r);
		chk(r, 8'h00);
		u_host.rd(8'h03, r);
		chk(r, 8'hfd);
		u_host.rd(8'h02, r);
		chk(r, 8'h88);
		// a second reset in mid-run must bring back the defaults
		@(posedge i_mclk);
		i_rst <= 1'b1;
		repeat (2) @(posedge i_mclk);
		i_rst <= 1'b0;
		chk({2'b00, ao}, 8'h00);
		chk({th, cur, 2'b0, ac}, 8'h00);
		u_host.rd(8'h02, r);
		chk(r, acl_pkg::RST_ANALOG_CONFIG);
		u_host.rd(8'h03, r);
		chk(r, acl_pkg::RST_LEAD_OFF_CONTROL);
		test_done;
	end
endmodule : tb_top
